// *** array_model.sv ***
// Array engine model: ends a program after a fixed busy time
module array_model #(parameter int BUSY_CYC = 40) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic suspend_in,
   input wire logic resume_in,
   output logic done_out
);
   int cnt_r;
   always_ff @(posedge clk_in) begin
      done_out <= 1'b0;
      if (!rst_n_in) cnt_r <= 0;
      else if (start_in || resume_in) cnt_r <= BUSY_CYC;
      else if (suspend_in) cnt_r <= 0;
      else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
         done_out <= (cnt_r == 1);
      end
   end
endmodule

// *** flash_prog_defines.svh ***
// Command codes, offsets and timing counts for the program command sequencer
`ifndef FLASH_PROG_DEFINES_SVH
`define FLASH_PROG_DEFINES_SVH
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_CONFIRM 8'h29
`define CMD_SUSP_A 8'hB0
`define CMD_SUSP_B 8'h51
`define CMD_RES_A 8'h30
`define CMD_RES_B 8'h50
`define CMD_SR_READ 8'h70
`define CMD_SR_CLEAR 8'h71
`define CMD_RESET 8'hF0
`define ADDR_UNLOCK1 12'h0555
`define ADDR_UNLOCK2 12'h02AA
`define MAX_WORDS 9'h0100
`define SR_READY_BIT 7
`define SR_ABORT_BIT 3
`define SR_BIT_ONE 1
`define CLK_MHZ 250
`define SUSPEND_LAT_NS 40000
`define SUSPEND_LAT_CYC ((`SUSPEND_LAT_NS * `CLK_MHZ + 999) / 1000)
`endif

// *** flash_prog_pkg.sv ***
// Types shared by the program command sequencer
package flash_prog_pkg;
   typedef enum logic [3:0] {
      read_state,
      buffer_load_start_state,
      buffer_load_data_state,
      buffer_full_state,
      single_word_setup_state,
      programming_state,
      programming_status_substate,
      suspend_pending_state,
      suspended_state,
      suspended_status_substate,
      abort_unlock_first_state,
      abort_unlock_second_state
   } prog_state_e;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] sector;
      logic [7:0] data;
   } bus_cycle_s;
endpackage

// *** flash_program_command_fsm.sv ***
// Program path command state machine of a parallel NOR flash
// Overview of operation
// RL1: Decode unlock AAh at 555h, confirm 29h, suspend B0h or 51h.
// RL2: Accept status read 70h, clear 71h at 555h, resume 30h or 50h.
// RL3: Buffer load aborts on count over 256 or address change; full at zero.
// RL4: Buffer full: confirm starts programming; any other write aborts into programming state.
// RL5: Single-word setup holds on reads; next data write starts programming.
// RL6: Busy: 70h to status substate, suspend to pending, else keep programming.
// RL7: Done: reset or status clear to read; unlock-1 enters abort unlock.
// RL8: Programming ends by itself into read mode on completion.
// RL9: First abort unlock holds on reads; 55h at 2AAh advances.
// RL10: Second abort unlock: F0h returns to read, clearing abort.
// RL11: Broken unlock sequence with abort flags set falls back to programming.
// RL12: Status substates deliver status on next read, then return.
// RL13: Suspend pending holds on reads; status read returns to pending after.
// RL14: Suspended: status read, clear keeps, resume restarts programming.
// RL15: Suspended status substate returns to suspended after its read.
// RL16: Suspend pending becomes suspended after the suspend latency.
//
// Chosen here: the register offsets and the plain strobed port.
`include "flash_prog_defines.svh"
module flash_program_command_fsm #(
   parameter int SUSPEND_CYC = `SUSPEND_LAT_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire flash_prog_pkg::bus_cycle_s cyc_in,
   input wire logic buffer_start_in,
   input wire logic word_setup_in,
   input wire logic [8:0] word_count_in,
   input wire logic [15:0] buffer_addr_in,
   input wire logic array_done_in,
   input wire logic program_fail_in,
   input wire logic [7:0] sr_clear_in,
   input wire logic [7:0] sr_enable_in,
   output logic [3:0] state_out,
   output logic start_program_out,
   output logic suspend_req_out,
   output logic resume_req_out,
   output logic sr_drive_out,
   output logic [7:0] status_out,
   output logic irq_out
);
   import flash_prog_pkg::*;

   prog_state_e state_r, state_nxt, return_r;
   logic [8:0] remain_r;
   logic [15:0] sector_address_r, buf_addr_r;
   logic ready_status_bit_r, buffer_abort_status_bit_r, status_bit_one_r;
   logic [31:0] susp_cnt_r;
   logic [7:0] evt_r;
   logic start_nxt;

   function automatic logic is_cmd(input bus_cycle_s c, input logic [7:0] d,
                                   input logic chk, input logic [11:0] a);
      is_cmd = c.wr && (c.data == d) && (!chk || (c.addr == a));
   endfunction

   logic sr_rd, sr_clr, sw_rst, unl1, unl2, suspend, resume, confirm, aborted;
   always_comb begin
      sr_rd = is_cmd(cyc_in, `CMD_SR_READ, 1'b1, `ADDR_UNLOCK1); // RL2
      sr_clr = is_cmd(cyc_in, `CMD_SR_CLEAR, 1'b1, `ADDR_UNLOCK1); // RL2
      sw_rst = is_cmd(cyc_in, `CMD_RESET, 1'b0, 12'h0000);
      unl1 = is_cmd(cyc_in, `CMD_UNLOCK1, 1'b1, `ADDR_UNLOCK1); // RL1
      unl2 = is_cmd(cyc_in, `CMD_UNLOCK2, 1'b1, `ADDR_UNLOCK2);
      suspend = is_cmd(cyc_in, `CMD_SUSP_A, 1'b0, 12'h0000) ||
                is_cmd(cyc_in, `CMD_SUSP_B, 1'b0, 12'h0000); // RL1
      resume = is_cmd(cyc_in, `CMD_RES_A, 1'b0, 12'h0000) ||
               is_cmd(cyc_in, `CMD_RES_B, 1'b0, 12'h0000); // RL2
      confirm = cyc_in.wr && (cyc_in.data == `CMD_CONFIRM) &&
                (cyc_in.sector == sector_address_r); // RL1
      aborted = buffer_abort_status_bit_r || status_bit_one_r;
   end

   always_comb begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      unique case (state_r)
         read_state: begin
            if (buffer_start_in) begin
               state_nxt = buffer_load_start_state;
            end else if (word_setup_in) begin
               state_nxt = single_word_setup_state;
            end
         end
         buffer_load_start_state: begin
            if (cyc_in.wr) begin
               if (word_count_in > `MAX_WORDS || cyc_in.sector != sector_address_r) begin
                  state_nxt = programming_state; // RL3
               end else if (word_count_in == 9'h000) begin
                  state_nxt = buffer_full_state; // RL3
               end else begin
                  state_nxt = buffer_load_data_state;
               end
            end
         end
         buffer_load_data_state: begin
            if (cyc_in.wr) begin
               if (cyc_in.sector != buf_addr_r) begin
                  state_nxt = programming_state; // RL3
               end else if (remain_r == 9'h001) begin
                  state_nxt = buffer_full_state; // RL3
               end
            end
         end
         buffer_full_state: begin
            if (cyc_in.wr) begin
               state_nxt = programming_state; // RL4
               start_nxt = confirm; // RL4
            end
         end
         single_word_setup_state: begin
            if (cyc_in.wr) begin
               state_nxt = programming_state; // RL5
               start_nxt = 1'b1; // RL5
            end
         end
         programming_state: begin
            if (!ready_status_bit_r) begin
               if (array_done_in) begin
                  state_nxt = read_state; // RL8
               end else if (sr_rd) begin
                  state_nxt = programming_status_substate; // RL6
               end else if (suspend) begin
                  state_nxt = suspend_pending_state; // RL6
               end
            end else if (sw_rst || sr_clr) begin
               state_nxt = read_state; // RL7
            end else if (sr_rd) begin
               state_nxt = programming_status_substate;
            end else if (unl1) begin
               state_nxt = abort_unlock_first_state; // RL7
            end
         end
         programming_status_substate, suspended_status_substate: begin
            if (cyc_in.rd || cyc_in.wr) begin
               state_nxt = return_r; // RL12 RL15
            end
         end
         suspend_pending_state: begin
            if (sr_rd) begin
               state_nxt = programming_status_substate; // RL13
            end else if (susp_cnt_r >= SUSPEND_CYC - 1) begin
               state_nxt = suspended_state; // RL16
            end
         end
         suspended_state: begin
            if (sr_rd) begin
               state_nxt = suspended_status_substate; // RL14
            end else if (resume) begin
               state_nxt = programming_state; // RL14
            end
         end
         abort_unlock_first_state: begin
            if (unl2) begin
               state_nxt = abort_unlock_second_state; // RL9
            end else if (cyc_in.wr && aborted) begin
               state_nxt = programming_state; // RL11
            end
         end
         abort_unlock_second_state: begin
            if (sw_rst) begin
               state_nxt = read_state; // RL10
            end else if (cyc_in.wr && aborted) begin
               state_nxt = programming_state; // RL11
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= read_state;
         return_r <= read_state;
      end else begin
         state_r <= state_nxt;
         // Remember where a status read came from
         if (state_nxt == programming_status_substate && state_r != programming_status_substate) begin
            return_r <= state_r;
         end else if (state_nxt == suspended_status_substate) begin
            return_r <= suspended_state;
         end
      end
   end

   // Buffer tracking: sector latched at buffer start in read state; count on first write
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         remain_r <= 9'h000;
         sector_address_r <= 16'h0000;
         buf_addr_r <= 16'h0000;
      end else if (buffer_start_in && state_r == read_state) begin
         sector_address_r <= cyc_in.sector;
         buf_addr_r <= buffer_addr_in;
      end else if (state_r == buffer_load_start_state && cyc_in.wr) begin
         remain_r <= word_count_in;
      end else if (state_r == buffer_load_data_state && cyc_in.wr) begin
         remain_r <= remain_r - 9'h001;
      end
   end

   // Latency counter; restarts whenever pending is entered
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || state_r != suspend_pending_state) begin
         susp_cnt_r <= 32'h0000_0000;
      end else begin
         susp_cnt_r <= susp_cnt_r + 32'h0000_0001;
      end
   end

   // Status bits; set wins over clear, except ready, where a start wins over done
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ready_status_bit_r <= 1'b1;
         buffer_abort_status_bit_r <= 1'b0;
         status_bit_one_r <= 1'b0;
      end else begin
         if (start_nxt || (state_r == suspended_state && resume)) begin
            ready_status_bit_r <= 1'b0;
         end else if (array_done_in || program_fail_in) begin
            ready_status_bit_r <= 1'b1;
         end
         if (state_r == buffer_full_state && cyc_in.wr && !confirm) begin
            buffer_abort_status_bit_r <= 1'b1;
         end else if ((state_r == buffer_load_start_state || state_r == buffer_load_data_state)
                      && state_nxt == programming_state) begin
            buffer_abort_status_bit_r <= 1'b1;
         end else if (state_r == abort_unlock_second_state && sw_rst) begin
            buffer_abort_status_bit_r <= 1'b0; // RL10
         end else if (sr_clr) begin
            buffer_abort_status_bit_r <= 1'b0;
         end
         if (program_fail_in) begin
            status_bit_one_r <= 1'b1;
         end else if (sr_clr || (state_r == abort_unlock_second_state && sw_rst)) begin
            status_bit_one_r <= 1'b0;
         end
      end
   end

   // Interrupt events: 0 done, 1 load abort, 2 fail, 3 suspended
   logic [7:0] evt_set;
   always_comb begin
      evt_set = 8'h00;
      evt_set[0] = array_done_in;
      evt_set[1] = (state_nxt == programming_state) && !start_nxt &&
                   (state_r == buffer_load_start_state || state_r == buffer_load_data_state);
      evt_set[2] = program_fail_in;
      evt_set[3] = (state_nxt == suspended_state) && (state_r == suspend_pending_state);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         evt_r <= 8'h00;
      end else begin
         evt_r <= evt_set | (evt_r & ~sr_clear_in);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_out <= 4'h0;
         start_program_out <= 1'b0;
         suspend_req_out <= 1'b0;
         resume_req_out <= 1'b0;
         sr_drive_out <= 1'b0;
         status_out <= 8'h80;
         irq_out <= 1'b0;
      end else begin
         state_out <= state_nxt;
         start_program_out <= start_nxt;
         suspend_req_out <= (state_nxt == suspend_pending_state) && (state_r == programming_state);
         resume_req_out <= (state_r == suspended_state) && resume;
         // Status is put on the bus in the cycle after a read in a status substate
         sr_drive_out <= cyc_in.rd && (state_r == programming_status_substate ||
                                       state_r == suspended_status_substate); // RL12
         status_out <= {ready_status_bit_r, 3'b000, buffer_abort_status_bit_r,
                        1'b0, status_bit_one_r, 1'b0};
         irq_out <= |((evt_set | (evt_r & ~sr_clear_in)) & sr_enable_in);
      end
   end
endmodule

// *** prog_checker_sva.sv ***
// Port assertions for the program command sequencer
module prog_checker import flash_prog_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire flash_prog_pkg::bus_cycle_s cyc_in,
   input wire logic array_done_in,
   input wire logic [3:0] state_out,
   input wire logic start_program_out,
   input wire logic suspend_req_out,
   input wire logic resume_req_out,
   input wire logic sr_drive_out,
   input wire logic [7:0] status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire w = cyc_in.wr;
   wire [7:0] d = cyc_in.data;
   setup_hold_a: assert property (
      state_out == single_word_setup_state && !w |=> state_out == single_word_setup_state)
      else $error("setup state left without write");
   word_start_a: assert property (
      state_out == single_word_setup_state && w |=> start_program_out)
      else $error("word write did not start");
   busy_suspend_a: assert property (
      state_out == programming_state && !status_out[7] && w && !array_done_in &&
      (d == 8'hB0 || d == 8'h51) |=> suspend_req_out && state_out == suspend_pending_state)
      else $error("suspend not taken");
   done_read_a: assert property (
      state_out == programming_state && array_done_in && !w |=> state_out == read_state)
      else $error("no return to read");
   unlock_two_a: assert property (
      state_out == abort_unlock_first_state && w && cyc_in.addr == 12'h2AA && d == 8'h55
      |=> state_out == abort_unlock_second_state)
      else $error("second unlock missed");
   abort_reset_a: assert property (
      state_out == abort_unlock_second_state && w && d == 8'hF0
      |=> state_out == read_state ##1 !status_out[3])
      else $error("abort reset missed");
   status_drive_a: assert property (
      (state_out == programming_status_substate || state_out == suspended_status_substate)
      && cyc_in.rd |=> sr_drive_out)
      else $error("status not driven");
   suspend_lat_a: assert property (
      $rose(suspend_req_out) |-> ##[1:24] state_out == suspended_state)
      else $error("suspend latency exceeded");
   resume_go_a: assert property (
      state_out == suspended_state && w && (d == 8'h30 || d == 8'h50)
      |=> resume_req_out && state_out == programming_state)
      else $error("resume not taken");
   cover property (state_out == suspended_state);
   cover property (state_out == abort_unlock_second_state);
   cover property (sr_drive_out);
endmodule
bind flash_program_command_fsm prog_checker u_chk (.*);

// *** tb.sv ***
// Self-checking bench for the program command sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_prog_pkg::*;
   logic clk_in = 0, rst_n_in = 0, buffer_start_in = 0, word_setup_in = 0;
   logic array_done_in, start_program_out, suspend_req_out, resume_req_out, sr_drive_out, irq_out;
   bus_cycle_s cyc_in = '{sector: 16'h0012, default: '0};
   logic [7:0] sr_clear_in = 8'h00, sr_enable_in = 8'h01, status_out;
   logic [8:0] word_count_in = 9'h000;
   logic [3:0] state_out;
   int fail_count = 0, total_checks = 0;
   always #2 clk_in = ~clk_in;
   // Same sector everywhere, so only the count can abort a load
   flash_program_command_fsm #(.SUSPEND_CYC(8)) DUT (.*, .buffer_addr_in(16'h0012),
      .program_fail_in(1'b0));
   array_model PM (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_program_out),
      .suspend_in(suspend_req_out), .resume_in(resume_req_out), .done_out(array_done_in));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic cyc(logic w, logic [11:0] a, logic [7:0] d);
      @(posedge clk_in);
      cyc_in <= '{wr: w, rd: !w, addr: a, sector: 16'h0012, data: d};
      @(posedge clk_in);
      cyc_in.wr <= 1'b0;
      cyc_in.rd <= 1'b0;
      #1;
   endtask
   task automatic tick2;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task automatic await(logic [3:0] s);
      for (int i = 0; i < 300 && state_out !== s; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk("state wait", s, state_out);
      if (state_out !== s) results;
   endtask
   task automatic load(logic [8:0] n);
      @(posedge clk_in);
      buffer_start_in <= 1'b1;
      word_count_in <= n;
      @(posedge clk_in);
      buffer_start_in <= 1'b0;
   endtask
   task automatic t_word;
      @(posedge clk_in);
      word_setup_in <= 1'b1;
      @(posedge clk_in);
      word_setup_in <= 1'b0;
      cyc(0, 12'h000, 8'h00);
      chk("setup hold", single_word_setup_state, state_out);
      cyc(1, 12'h100, 8'h5A);
      chk("start pulse", 1, start_program_out);
      cyc(1, 12'h100, 8'h5A);
      chk("busy write", programming_state, state_out);
      chk("ready low", 0, status_out[7]);
      await(read_state);
      tick2;
      chk("irq set", 1, irq_out);
      sr_enable_in <= 8'h00;
      tick2;
      chk("irq masked", 0, irq_out);
      sr_enable_in <= 8'h01;
      sr_clear_in <= 8'h01;
      @(posedge clk_in);
      sr_clear_in <= 8'h00;
      tick2;
      chk("irq cleared", 0, irq_out);
      $display("word test done");
   endtask
   task automatic t_abort(logic brk);
      load(9'h101);
      cyc(1, 12'h000, 8'h11);
      chk("count abort", programming_state, state_out);
      cyc(1, 12'h555, 8'hAA);
      chk("unlock one", abort_unlock_first_state, state_out);
      // Status lags the state by one cycle
      chk("abort flag", 1, status_out[3]);
      cyc(0, 12'h555, 8'h00);
      chk("unlock read", abort_unlock_first_state, state_out);
      cyc(1, 12'h2AA, brk ? 8'h54 : 8'h55);
      if (brk) begin
         chk("broken unlock", programming_state, state_out);
         cyc(1, 12'h555, 8'h71);
      end else begin
         chk("unlock two", abort_unlock_second_state, state_out);
         cyc(1, 12'h000, 8'hF0);
      end
      chk("back to read", read_state, state_out);
      tick2;
      chk("flag clear", 0, status_out[3]);
      $display("abort test done");
   endtask
   task automatic t_buffer;
      logic [7:0] sus [2] = '{8'hB0, 8'h51};
      logic [7:0] res [2] = '{8'h50, 8'h30};
      load(9'h001);
      cyc(1, 12'h000, 8'h11);
      cyc(1, 12'h001, 8'h22);
      chk("buffer full", buffer_full_state, state_out);
      cyc(1, 12'h000, 8'h29);
      chk("confirm", 1, start_program_out);
      foreach (sus[i]) begin
         cyc(1, 12'h555, 8'h70);
         chk("busy status", programming_status_substate, state_out);
         cyc(0, 12'h000, 8'h00);
         chk("status drive", 1, sr_drive_out);
         chk("status back", programming_state, state_out);
         cyc(1, 12'h000, sus[i]);
         chk("suspend req", 1, suspend_req_out);
         cyc(1, 12'h555, 8'h70);
         cyc(0, 12'h000, 8'h00);
         chk("pending back", suspend_pending_state, state_out);
         await(suspended_state);
         cyc(1, 12'h555, 8'h71);
         chk("clear keeps", suspended_state, state_out);
         cyc(1, 12'h555, 8'h70);
         cyc(0, 12'h000, 8'h00);
         chk("suspended back", suspended_state, state_out);
         cyc(1, 12'h000, res[i]);
         chk("resume", 1, resume_req_out);
      end
      await(read_state);
      $display("buffer test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_word;
      t_abort(1'b1);
      t_abort(1'b0);
      t_buffer;
      results;
   end
endmodule
